//--- ssr_pkg.sv
// ssr_pkg: constants for the serial status readback block of a smart
// high-side switch: command byte layout, register codes, status maps.
// assumes the host is the spi master, clock idle low, frames framed by
// an active-low chip select.
//
// Notes on behaviour
// - chip select low loads selected status byte
// - status shifts out msb first during command
// - after eight bits, echo received input bits
// - accept frame only at multiple of eight
// - select high: output tristate, faults update again
// - invalid frame changes neither selection nor status
// - bit 7 echoes previous watchdog feed bit, except codes 101 and 110
// - select code and alt bit choose map
// - code 000 returns the fault flags
// - overcurrent flags latch; undervoltage latching optional
// - summary fault set by faults, cleared by read
// - code 001 returns output control settings
// - code 010 returns overcurrent level selects
// - code 011 returns blanking and disables
// - code 100 returns direct input configuration
// - code 101 alt 0 returns delay, failsafe
// - code 101 alt 1 returns watchdog state
// - code 110 alt 0 returns live pin levels
// - code 110 alt 1 returns supply protection disables
// - code 111 returns null data, variant bit

package ssr_pkg;

   // =====================================================================
   // command byte layout
   localparam int          BYTE_BITS      = 8;
   localparam int          CMD_WD_BIT     = 7;
   localparam int          CMD_ADDR_HI    = 6;
   localparam int          CMD_ADDR_LO    = 4;
   localparam int          CMD_ALT_BIT    = 3;
   localparam logic [2:0]  BIT_CNT_ZERO   = 3'h0;
   localparam logic [3:0]  OUT_IDX_FIRST  = 4'h1;
   localparam logic [3:0]  OUT_IDX_ECHO   = 4'h8;

   // =====================================================================
   // register codes (three low address bits)
   localparam logic [2:0]  ADDR_STATUS    = 3'h0;
   localparam logic [2:0]  ADDR_OUTPUT    = 3'h1;
   localparam logic [2:0]  ADDR_OCLEVEL   = 3'h2;
   localparam logic [2:0]  ADDR_BLANKING  = 3'h3;
   localparam logic [2:0]  ADDR_DIRECT    = 3'h4;
   localparam logic [2:0]  ADDR_DELAY_WD  = 3'h5;
   localparam logic [2:0]  ADDR_NOP_SUPP  = 3'h6;
   localparam logic [2:0]  ADDR_TEST_NULL = 3'h7;

   // =====================================================================
   // fault_flags bit positions (status map 000)
   localparam int          FLT_OT         = 6;
   localparam int          FLT_OCH        = 5;
   localparam int          FLT_OCL        = 4;
   localparam int          FLT_OL         = 3;
   localparam int          FLT_UV         = 2;
   localparam int          FLT_OV         = 1;
   localparam int          FLT_SUM        = 0;

   // =====================================================================
   // reset values
   localparam logic [7:0]  FAULT_RESET    = 8'h00;
   localparam logic [2:0]  SEL_RESET      = 3'h7;
   localparam logic        ALT_RESET      = 1'b0;
   localparam logic [3:0]  CFG4_RESET     = 4'h0;
   localparam logic [2:0]  CFG3_RESET     = 3'h0;
   localparam logic [1:0]  CFG2_RESET     = 2'h0;
   localparam logic [7:0]  STATUS_RESET   = 8'h00;
   localparam logic [2:0]  NULL_DATA      = 3'h0;

endpackage : ssr_pkg

//--- ssr_status_readback.sv
// ssr_status_readback: spi slave of the switch. shifts out the selected
// status byte while a command shifts in, echoes input for daisy chains,
// checks frame length at chip select rise and latches valid commands.
// assumes: sclk idles low and stands still while csN is high; the host
// leaves at least four mclk periods between csN fall and the first sclk
// rise, and between the last sclk fall and csN rise.

`timescale 1ns/100ps

module ssr_status_readback #(
   parameter bit UV_LATCHED  = 1'b1,   // undervoltage flag sticky when set
   parameter bit VARIANT_BIT = 1'b0    // arbitrary value, variant indicator
) (
   input  wire logic       mclk,
   input  wire logic       resetn,
   // spi pins
   input  wire logic       sclk,
   input  wire logic       csN,
   input  wire logic       si,
   output logic            so,
   output logic            soOe,
   // live pins, asynchronous to mclk
   input  wire logic       directInPin,
   input  wire logic       failsafeInPin,
   input  wire logic       wakeupPin,
   // fault conditions from the power stage, mclk domain
   input  wire logic       overTempIn,
   input  wire logic       overCurrentHighIn,
   input  wire logic       overCurrentLowIn,
   input  wire logic       openLoadIn,
   input  wire logic       underVoltageIn,
   input  wire logic       overVoltageIn,
   input  wire logic       watchdogTimedOutIn,
   input  wire logic       failsafeOutputStateIn,
   // latched configuration to the power stage, then feed echo, accept pulse, fault pin
   output logic            outputOnCommand,
   output logic            currentSenseEnable,
   output logic            overcurrentHighLevelSelect,
   output logic [2:0]      overcurrentLowLevelSelect,
   output logic            openLoadDetectDisable,
   output logic            overcurrentTimeoutDisable,
   output logic [1:0]      blankingTimeSelect,
   output logic            fastSlewSelect,
   output logic            highSenseRatioSelect,
   output logic            directInputDisable,
   output logic            andOrSelect,
   output logic [2:0]      turnOnDelaySelect,
   output logic [1:0]      watchdogPeriodSelect,
   output logic            undervoltageProtectDisable,
   output logic            overvoltageProtectDisable,
   output logic            watchdogFeedEcho,
   output logic            frameAccepted,
   output logic            faultIndicatorOutput
);

   // =====================================================================
   // link side: sclk domain
   logic [7:0]  rxShift;        // last eight bits taken from si
   logic [2:0]  rxBitMod;       // bits received modulo eight
   logic        rxToggle;       // flips once per frame that had bits
   logic        rxStarted;
   logic        txStarted;
   logic [3:0]  outIdx;

   // =====================================================================
   // core side: mclk domain
   logic        csMeta;
   logic        csSync;
   logic        csPrev;
   logic        togMeta;
   logic        togSync;
   logic        togSeen;
   logic [2:0]  pinMeta;
   logic [7:0]  inputPinLevels;
   logic [7:0]  faultFlags;
   logic [7:0]  statusLoad;     // frozen for sclk domain during frame
   logic [7:0]  next_status;
   logic [2:0]  statusSelectCode;
   logic        altMapSelectBit;
   logic        csFall;
   logic        csRise;
   logic        frameValid;
   logic        readFaultMap;
   logic [2:0]  cmdAddr;
   logic        cmdAlt;
   logic [3:0]  cmdData;

   // =====================================================================
   // transmit: drive on rising edge, first edge puts bit 7 out
   // frame state is cleared by csN itself since sclk stops between frames
   always_ff @(posedge sclk or posedge csN or negedge resetn) begin
      if (!resetn) begin
         txStarted <= 1'b0;
         outIdx    <= 4'h0;
         so        <= 1'b0;
         soOe      <= 1'b0;
      end else if (csN) begin
         txStarted <= 1'b0;
         outIdx    <= 4'h0;
         so        <= 1'b0;
         soOe      <= 1'b0;   // release pin at chip select high
      end else if (!txStarted) begin
         txStarted <= 1'b1;
         outIdx    <= ssr_pkg::OUT_IDX_FIRST;
         so        <= statusLoad[ssr_pkg::BYTE_BITS-1];   // msb first
         soOe      <= 1'b1;
      end else if (outIdx < ssr_pkg::OUT_IDX_ECHO) begin
         outIdx    <= outIdx + ssr_pkg::OUT_IDX_FIRST;
         so        <= statusLoad[3'(ssr_pkg::BYTE_BITS - 1 - int'(outIdx))];
      // outIdx parks at eight: from then on so only echoes si
      end else begin
         so        <= rxShift[ssr_pkg::BYTE_BITS-1];   // oldest of the last eight
      end
   end

   // first-edge marker for receive, also cleared by csN
   always_ff @(negedge sclk or posedge csN or negedge resetn) begin
      if (!resetn) begin
         rxStarted <= 1'b0;
      end else if (csN) begin
         rxStarted <= 1'b0;
      end else begin
         rxStarted <= 1'b1;
      end
   end

   // receive: sample si on falling edge; not cleared by csN so the core
   // can read them once the frame is over
   always_ff @(negedge sclk or negedge resetn) begin
      if (!resetn) begin
         rxShift  <= 8'h00;
         rxBitMod <= ssr_pkg::BIT_CNT_ZERO;
         rxToggle <= 1'b0;
      end else begin
         // shifter keeps running in a long frame, so the last byte wins
         rxShift <= {rxShift[ssr_pkg::BYTE_BITS-2:0], si};
         if (!rxStarted) begin
            rxBitMod <= 3'h1;
            rxToggle <= ~rxToggle;   // marks a frame that carried bits
         end else begin
            rxBitMod <= rxBitMod + 3'h1;   // wraps at eight
         end
      end
   end

   // =====================================================================
   // synchronisers: chip select, frame toggle and live pins
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         csMeta  <= 1'b1;
         csSync  <= 1'b1;
         csPrev  <= 1'b1;
         togMeta <= 1'b0;
         togSync <= 1'b0;
         pinMeta <= 3'h0;
         inputPinLevels <= 8'h00;
      end else begin
         csMeta  <= csN;
         csSync  <= csMeta;
         csPrev  <= csSync;
         togMeta <= rxToggle;
         togSync <= togMeta;
         pinMeta <= {directInPin, failsafeInPin, wakeupPin};
         inputPinLevels <= {5'h00, pinMeta};   // live levels
      end
   end

   assign csFall = csPrev && !csSync;
   assign csRise = !csPrev && csSync;

   // rxShift and rxBitMod stand still once csN is high: sclk is idle
   // the toggle test rejects a frame that carried no clock edge at all
   assign frameValid   = csRise && (togSync != togSeen)
                         && (rxBitMod == ssr_pkg::BIT_CNT_ZERO);
   assign cmdAddr      = rxShift[ssr_pkg::CMD_ADDR_HI:ssr_pkg::CMD_ADDR_LO];
   assign cmdAlt       = rxShift[ssr_pkg::CMD_ALT_BIT];
   assign cmdData      = rxShift[3:0];
   // only a read of the fault map clears the sticky flags
   assign readFaultMap = frameValid && (statusSelectCode == ssr_pkg::ADDR_STATUS);

   // remember which frame toggle has been consumed
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         togSeen <= 1'b0;
      end else if (csRise) begin
         togSeen <= togSync;
      end
   end

   // =====================================================================
   // fault flags: frozen while a frame runs, updated after csN rise
   // a fault present in the clearing cycle wins over the read clear
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         faultFlags <= ssr_pkg::FAULT_RESET;
      end else if (csSync) begin
         // flags without a latch follow their inputs while select is high; ov, and uv when not latched, are masked by their protect disables
         faultFlags[7]                <= 1'b0;
         faultFlags[ssr_pkg::FLT_OT]  <= overTempIn;
         faultFlags[ssr_pkg::FLT_OCH] <= overCurrentHighIn
                                         || (faultFlags[ssr_pkg::FLT_OCH] && !readFaultMap);
         faultFlags[ssr_pkg::FLT_OCL] <= overCurrentLowIn
                                         || (faultFlags[ssr_pkg::FLT_OCL] && !readFaultMap);
         faultFlags[ssr_pkg::FLT_OL]  <= openLoadIn;
         faultFlags[ssr_pkg::FLT_UV]  <= (underVoltageIn && !undervoltageProtectDisable)
                                         || (UV_LATCHED && faultFlags[ssr_pkg::FLT_UV] && !readFaultMap);
         faultFlags[ssr_pkg::FLT_OV]  <= overVoltageIn && !overvoltageProtectDisable;
         faultFlags[ssr_pkg::FLT_SUM] <= overTempIn || overCurrentHighIn || overCurrentLowIn || openLoadIn
                                         || underVoltageIn || overVoltageIn
                                         || (faultFlags[ssr_pkg::FLT_SUM] && !readFaultMap);
      end
   end

   // fault pin mirrors the summary flag
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         faultIndicatorOutput <= 1'b0;
      end else begin
         // one cycle behind the flag: the price of a flopped output
         faultIndicatorOutput <= faultFlags[ssr_pkg::FLT_SUM];
      end
   end

   // =====================================================================
   // status map: bit 7 is the previous feed bit unless fixed
   always_comb begin
      next_status = {watchdogFeedEcho, 7'h00};
      case (statusSelectCode)
         ssr_pkg::ADDR_STATUS: begin
            next_status[6:0] = faultFlags[6:0];
         end
         ssr_pkg::ADDR_OUTPUT: begin
            next_status[6:0] = {ssr_pkg::ADDR_OUTPUT, 2'h0, currentSenseEnable, outputOnCommand};
         end
         ssr_pkg::ADDR_OCLEVEL: begin
            next_status[6:0] = {ssr_pkg::ADDR_OCLEVEL, overcurrentHighLevelSelect,
                                overcurrentLowLevelSelect};
         end
         ssr_pkg::ADDR_BLANKING: begin
            next_status[6:0] = {ssr_pkg::ADDR_BLANKING, openLoadDetectDisable, overcurrentTimeoutDisable,
                                blankingTimeSelect};
         end
         ssr_pkg::ADDR_DIRECT: begin
            next_status[6:0] = {ssr_pkg::ADDR_DIRECT, fastSlewSelect, highSenseRatioSelect, directInputDisable,
                                andOrSelect};
         end
         // codes 101 and 110 fix bit 7 themselves, so they set all eight bits
         ssr_pkg::ADDR_DELAY_WD: begin
            if (!altMapSelectBit) begin
               next_status = {1'b0, ssr_pkg::ADDR_DELAY_WD, failsafeOutputStateIn, turnOnDelaySelect};
            end else begin
               next_status = {1'b1, ssr_pkg::ADDR_DELAY_WD, 1'b0, watchdogTimedOutIn,
                              watchdogPeriodSelect};
            end
         end
         ssr_pkg::ADDR_NOP_SUPP: begin
            if (!altMapSelectBit) begin
               next_status = {1'b0, ssr_pkg::ADDR_NOP_SUPP, 1'b0, inputPinLevels[2:0]};
            end else begin
               next_status = {1'b1, ssr_pkg::ADDR_NOP_SUPP, 2'h0, undervoltageProtectDisable,
                              overvoltageProtectDisable};
            end
         end
         ssr_pkg::ADDR_TEST_NULL: begin
            next_status[6:0] = {ssr_pkg::ADDR_TEST_NULL, VARIANT_BIT, ssr_pkg::NULL_DATA};
         end
         default: begin
            next_status[6:0] = 7'h00;
         end
      endcase
   end

   // capture the status byte at chip select fall, hold it for the frame
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         // taken behind the csN synchroniser, hence the host's four-cycle lead
         statusLoad <= ssr_pkg::STATUS_RESET;
      end else if (csFall) begin
         statusLoad <= next_status;
      end
   end

   // =====================================================================
   // status selection: only a valid status command moves it
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         statusSelectCode <= ssr_pkg::SEL_RESET;
         altMapSelectBit  <= ssr_pkg::ALT_RESET;
      // the alt bit only matters for codes 101 and 110
      end else if (frameValid && (cmdAddr == ssr_pkg::ADDR_STATUS)) begin
         statusSelectCode <= cmdData[2:0];
         altMapSelectBit  <= cmdAlt;
      end
   end

   // watchdog feed echo and the accept pulse
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         watchdogFeedEcho <= 1'b0;
         frameAccepted    <= 1'b0;
      end else begin
         frameAccepted <= frameValid;
         if (frameValid) begin
            // echo moves only on an accepted frame, so a cut frame feeds nothing
            watchdogFeedEcho <= rxShift[ssr_pkg::CMD_WD_BIT];
         end
      end
   end

   // =====================================================================
   // configuration registers, written by the last byte of a valid frame;
   // in a daisy chain that byte is the one meant for this device
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         outputOnCommand            <= 1'b0;
         currentSenseEnable         <= 1'b0;
         overcurrentHighLevelSelect <= 1'b0;
         overcurrentLowLevelSelect  <= ssr_pkg::CFG3_RESET;
         openLoadDetectDisable      <= 1'b0;
         overcurrentTimeoutDisable  <= 1'b0;
         blankingTimeSelect         <= ssr_pkg::CFG2_RESET;
         fastSlewSelect             <= 1'b0;
         highSenseRatioSelect       <= 1'b0;
         directInputDisable         <= 1'b0;
         andOrSelect                <= 1'b0;
         turnOnDelaySelect          <= ssr_pkg::CFG3_RESET;
         watchdogPeriodSelect       <= ssr_pkg::CFG2_RESET;
         undervoltageProtectDisable <= 1'b0;
         overvoltageProtectDisable  <= 1'b0;
      end else if (frameValid) begin   // invalid frames leave all as is
         // only the addressed register moves; the test code is never written
         case (cmdAddr)
            ssr_pkg::ADDR_OUTPUT: begin
               currentSenseEnable <= cmdData[1];
               outputOnCommand    <= cmdData[0];
            end
            ssr_pkg::ADDR_OCLEVEL: begin
               overcurrentHighLevelSelect <= cmdData[3];
               overcurrentLowLevelSelect  <= cmdData[2:0];
            end
            ssr_pkg::ADDR_BLANKING: begin
               openLoadDetectDisable     <= cmdData[3];
               overcurrentTimeoutDisable <= cmdData[2];
               blankingTimeSelect        <= cmdData[1:0];
            end
            ssr_pkg::ADDR_DIRECT: begin
               fastSlewSelect       <= cmdData[3];
               highSenseRatioSelect <= cmdData[2];
               directInputDisable   <= cmdData[1];
               andOrSelect          <= cmdData[0];
            end
            ssr_pkg::ADDR_DELAY_WD: begin
               if (cmdAlt) begin
                  watchdogPeriodSelect <= cmdData[1:0];
               end else begin
                  turnOnDelaySelect <= cmdData[2:0];
               end
            end
            ssr_pkg::ADDR_NOP_SUPP: begin
               if (cmdAlt) begin
                  undervoltageProtectDisable <= cmdData[1];
                  overvoltageProtectDisable  <= cmdData[0];
               end
            end
            default: begin
               // status select handled above; test code lands here and writes nothing
            end
         endcase
      end
   end

endmodule // ssr_status_readback

//--- ssr_host_model.sv
// ssr_host_model: spi master standing in for the host controller.
// assumes mode 1 wiring to the switch; the bench calls xfer by name.
`timescale 1ns/100ps
module ssr_host_model (
   output logic      sclk,
   output logic      csN,
   output logic      si,
   input  wire logic so
);
   // idle: clock low and still, select high
   initial begin
      sclk = 1'b0;
      csN  = 1'b1;
      si   = 1'b0;
   end
   // ======================================================================
   // one frame, msb first, link clock period 30 ns, no phase tie to mclk
   task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx  = 16'h0000;
      csN = 1'b0;
      #250;                 // status capture needs four mclk before first edge
      for (int i = n - 1; i >= 0; i--) begin
         sclk = 1'b1;
         #5 si = tx[i];     // change after the device launch edge
         #10 sclk = 1'b0;
         rx[i] = so;        // sample on the falling edge
         #15;
      end
      #250 csN = 1'b1;
      si = ~si;             // released line must not keep looking valid
      #400;                 // evaluation time plus gap between frames
   endtask
endmodule // ssr_host_model

//--- ssr_status_readback_checker.sv
// ssr_status_readback_checker: port-level assertions on the readback block.
// assumes it is bound to ssr_status_readback and sees only its ports.
`timescale 1ns/100ps
module ssr_status_readback_checker (
   input wire logic       mclk,
   input wire logic       resetn,
   input wire logic       sclk,
   input wire logic       csN,
   input wire logic       overTempIn,
   input wire logic       soOe,
   input wire logic       frameAccepted,
   input wire logic       watchdogFeedEcho,
   input wire logic       faultIndicatorOutput,
   input wire logic       outputOnCommand,
   input wire logic       currentSenseEnable,
   input wire logic [2:0] overcurrentLowLevelSelect,
   input wire logic [1:0] blankingTimeSelect,
   input wire logic [2:0] turnOnDelaySelect,
   input wire logic [1:0] watchdogPeriodSelect
);
   // ======================================================================
   // serial pin drive
   AST_SOOE_OFF: assert property (@(posedge mclk) disable iff (!resetn) csN |-> !soOe)
      else $error("serial output driven while deselected");
   AST_SOOE_ON: assert property (@(negedge sclk) disable iff (!resetn) !csN |-> soOe)
      else $error("serial output not driven inside frame");
   // ======================================================================
   // frame acceptance: a single pulse, only after select has been high a while
   AST_ACC_PULSE: assert property (@(posedge mclk) disable iff (!resetn) frameAccepted |=> !frameAccepted)
      else $error("accept pulse longer than one cycle");
   AST_ACC_LATE: assert property (@(posedge mclk) disable iff (!resetn)
      frameAccepted |-> csN && $past(csN, 2))
      else $error("frame accepted while select low");
   // config and feed echo move only with an accepted frame
   AST_CFG_HOLD: assert property (@(posedge mclk) disable iff (!resetn) !frameAccepted |-> $stable({outputOnCommand,
      currentSenseEnable, overcurrentLowLevelSelect, blankingTimeSelect, turnOnDelaySelect, watchdogPeriodSelect}))
      else $error("config changed without accepted frame");
   AST_ECHO_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
      !frameAccepted |-> $stable(watchdogFeedEcho))
      else $error("feed echo changed without accepted frame");
   // ======================================================================
   // summary fault: set by a fault, only cleared around an accepted read
   AST_FLT_SET: assert property (@(posedge mclk) disable iff (!resetn)
      overTempIn && csN && $past(csN, 3) |-> ##[1:3] faultIndicatorOutput)
      else $error("fault not reported");
   AST_FLT_CLR: assert property (@(posedge mclk) disable iff (!resetn)
      $fell(faultIndicatorOutput) |-> $past(frameAccepted) || $past(frameAccepted, 2))
      else $error("fault cleared without read");
   COV_ACC: cover property (@(posedge mclk) disable iff (!resetn) frameAccepted);
   COV_CLR: cover property (@(posedge mclk) disable iff (!resetn) $fell(faultIndicatorOutput));
   COV_DRV: cover property (@(negedge sclk) disable iff (!resetn) soOe);
endmodule // ssr_status_readback_checker

bind ssr_status_readback ssr_status_readback_checker u_chk (.mclk(mclk), .resetn(resetn), .sclk(sclk), .csN(csN),
   .overTempIn(overTempIn), .soOe(soOe), .frameAccepted(frameAccepted), .watchdogFeedEcho(watchdogFeedEcho),
   .faultIndicatorOutput(faultIndicatorOutput), .outputOnCommand(outputOnCommand),
   .currentSenseEnable(currentSenseEnable), .overcurrentLowLevelSelect(overcurrentLowLevelSelect),
   .blankingTimeSelect(blankingTimeSelect), .turnOnDelaySelect(turnOnDelaySelect),
   .watchdogPeriodSelect(watchdogPeriodSelect));

//--- spi_status_readback_tb.sv
// spi_status_readback_tb: self-checking bench for the status readback block.
// assumes ssr_host_model as spi master and the bound checker alongside.
`timescale 1ns/100ps
module spi_status_readback_tb;
   logic        mclk, resetn, sclk, csN, si, so, soOe, dirPin, fsiPin, wakePin, watchdog_timed_out, fsm;
   logic [5:0]  flt;
   logic [15:0] rx;
   logic        onCmd, csEn, ochSel, olDis, toDis, fastSr, hiSense, dirDis, andOr, uvDis, ovDis, feed, acc, fltInd;
   logic [2:0]  oclSel, delaySel;
   logic [1:0]  blankSel, wdSel;
   int          err_count, num_checks, accCount, n0;
   logic [7:0]  wr [8] = '{8'h13, 8'h2D, 8'h36, 8'h4B, 8'h53, 8'h5A, 8'h6B, 8'h60};
   logic [7:0]  sl [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h0D, 8'h0E, 8'h06};
   logic [7:0]  ex [8] = '{8'h13, 8'h2D, 8'h36, 8'h4B, 8'h5B, 8'hD6, 8'hE3, 8'h65};

   ssr_status_readback u_dut (.mclk(mclk), .resetn(resetn), .sclk(sclk), .csN(csN), .si(si), .so(so), .soOe(soOe),
      .directInPin(dirPin), .failsafeInPin(fsiPin), .wakeupPin(wakePin), .overTempIn(flt[0]),
      .overCurrentHighIn(flt[1]), .overCurrentLowIn(flt[2]), .openLoadIn(flt[3]), .underVoltageIn(flt[4]),
      .overVoltageIn(flt[5]), .watchdogTimedOutIn(watchdog_timed_out), .failsafeOutputStateIn(fsm), .outputOnCommand(onCmd),
      .currentSenseEnable(csEn), .overcurrentHighLevelSelect(ochSel), .overcurrentLowLevelSelect(oclSel),
      .openLoadDetectDisable(olDis), .overcurrentTimeoutDisable(toDis), .blankingTimeSelect(blankSel),
      .fastSlewSelect(fastSr), .highSenseRatioSelect(hiSense), .directInputDisable(dirDis), .andOrSelect(andOr),
      .turnOnDelaySelect(delaySel), .watchdogPeriodSelect(wdSel), .undervoltageProtectDisable(uvDis),
      .overvoltageProtectDisable(ovDis), .watchdogFeedEcho(feed), .frameAccepted(acc), .faultIndicatorOutput(fltInd));
   ssr_host_model u_host (.sclk(sclk), .csN(csN), .si(si), .so(so));

   // ======================================================================
   // clock, accepted-frame counter, shared tasks
   always #25 mclk = ~mclk;
   always @(posedge mclk) if (acc === 1'b1) accCount++;

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic send(input logic [7:0] c);
      u_host.xfer({8'h00, c}, 8, rx);
   endtask
   // pulse one fault input while select is high, so the flags may update
   task automatic pulse(input int k);
      @(negedge mclk) flt[k] = 1'b1;
      repeat (5) @(negedge mclk);
      flt[k] = 1'b0;
      repeat (5) @(negedge mclk);
   endtask
   task automatic results();
      if (err_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ======================================================================
   // main sequence
   initial begin
      {mclk, resetn, flt, err_count, num_checks, accCount} = '0;
      {dirPin, fsiPin, wakePin, watchdog_timed_out, fsm} = 5'b10111;
      repeat (3) @(negedge mclk);
      resetn = 1'b1;
      repeat (3) @(negedge mclk);
      send(8'h60);                                 // return discarded after reset
      send(8'h60);
      check(rx[7:0], 8'h70);
      send(8'h00);
      for (int k = 0; k < 6; k++) begin
         pulse(k);
         check(fltInd, 1'b1);
         send(8'h60);
         check(rx[7:0], 8'h01 | ((k inside {1, 2, 4}) ? (8'h40 >> k) : 8'h00));
         send(8'h60);
         check(rx[7:0], 8'h00);
      end
      check(fltInd, 1'b0);
      // short and empty frames are dropped whole, latched flag survives
      pulse(1);
      n0 = accCount;
      u_host.xfer(16'h0001, 7, rx);
      u_host.xfer(16'h0000, 0, rx);
      check(accCount, n0);
      send(8'h60);
      check(rx[7:0], 8'h21);
      u_host.xfer(16'hA560, 16, rx);
      check(rx, 16'h00A5);
      check(accCount, n0 + 2);
      // readback maps 001 to 110; feed bit toggles on the select commands
      for (int i = 0; i < 8; i++) begin
         send(wr[i]);
         send(sl[i] | {i[0], 7'h00});
         check(feed, i[0]);
         send(8'h60);
         check(rx[7:0] & ((i == 6) ? 8'hFB : 8'hFF), ex[i] | ((i > 3) ? 8'h00 : {i[0], 7'h00}));
      end
      check({onCmd, csEn, ochSel, oclSel, olDis, toDis, blankSel, fastSr, hiSense, dirDis, andOr, delaySel, wdSel,
         uvDis, ovDis}, 24'h1EB5BB);
      results();
   end

   // watchdog against a hung handshake
   initial begin
      #200000;
      err_count++;
      results();
   end
endmodule // spi_status_readback_tb
